// *** hdl/pro_fifo.sv ***
// Purpose: small pixel fifo in front of the pad mapper
// Assumes: width and depth given by parameters, depth a power of two
// Notes:   full and empty are exact; push and pop may share a cycle
`timescale 1ns/100ps
module pro_fifo #(
  parameter int W     = 30,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // filling side
  pro_stream_if.snk in_s,
  // draining side
  pro_stream_if.src out_s
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wr;
    logic [AW-1:0]           rd;
    logic [AW:0]             cnt;
  } pro_fifo_s;

  pro_fifo_s st_q, st_d;
  logic      push, pop;

  assign in_s.ready  = (st_q.cnt != (AW+1)'(DEPTH));
  assign out_s.valid = (st_q.cnt != '0);
  assign out_s.data  = st_q.mem[st_q.rd];
  assign push        = in_s.valid & in_s.ready;
  assign pop         = out_s.valid & out_s.ready;

  always_comb begin
    st_d = st_q;
    if (push) begin
      st_d.mem[st_q.wr] = in_s.data;
      st_d.wr           = st_q.wr + 1'b1;
    end
    if (pop) begin
      st_d.rd = st_q.rd + 1'b1;
    end
    case ({push, pop})
      2'b10:   st_d.cnt = st_q.cnt + 1'b1;
      2'b01:   st_d.cnt = st_q.cnt - 1'b1;
      default: st_d.cnt = st_q.cnt;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
endmodule : pro_fifo

// *** hdl/pro_output_stage.sv ***
// Purpose: map rgb pixels to 30 panel pads, make data enable and data clock
// Assumes: everything on the pixel clock; sync references come from logic on it
// Notes:   pads are registered so software levels show one edge after writing
`timescale 1ns/100ps
// Contract
// - swap option reverses component bit order
// - swapped 3x10 puts R9..R0,G9..G0,B9..B0
// - mux 3x10 sends two phases on P0..P14
// - data enable built from registers and references
// - data enable made on pixel clock
// - register bit selects data enable polarity
// - data clock polarity and four delays
// - data clock undivided or divided by two
// - per pad function bit and level bit
// - reconfigurable pads always push-pull outputs
// - software level appears at next clock edge
// - software control on P12..P29, enable, vsync, clock
// - seven registers at offsets 0x00 to 0x18
module pro_output_stage
  import pro_pkg::*;
#(
  parameter int FIFO_W = pro_pkg::PIX_W,
  parameter int FIFO_D = pro_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                        clock,
  input  wire logic                        rst_b,
  // register port
  input  wire logic                        reg_sel,
  input  wire logic                        reg_write,
  input  wire logic [pro_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [31:0]                 reg_wdata,
  output logic      [31:0]                 reg_rdata,
  output logic                             reg_ack,
  // pixel stream from the display pipeline
  input  wire logic                        pix_valid,
  input  wire logic [pro_pkg::PIX_W-1:0]   pix_rgb,
  output logic                             pix_ready,
  // timing references from the pixel domain
  input  wire logic                        pixel_hsync_ref,
  input  wire logic                        pixel_vertical_reset_ref,
  input  wire logic [pro_pkg::WIN_W-1:0]   pixel_line_counter,
  input  wire logic                        pixel_vsync_ref,
  // panel pads
  output logic      [pro_pkg::PAD_W-1:0]   video_pad,
  output logic                             data_enable_pad,
  output logic                             vsync_pad,
  output logic                             data_clock_pad
);
  import pro_pkg::*;

  typedef struct packed {
    logic [31:0]            ctrl;
    logic [31:0]            hsync_ctrl;
    logic [31:0]            vsync_ctrl;
    logic [31:0]            de_hwin;
    logic [31:0]            de_vwin;
    logic [31:0]            pad_func;
    logic [31:0]            pad_level;
    logic [31:0]            rdata;
    logic                   ack;
    logic                   hs_prev;
    logic [WIN_W-1:0]       hcnt;
    logic                   de;
    logic                   phase;
    logic                   clk_tgl;
    logic                   clk_div;
    logic [DCLK_TAPS-1:0]   clk_dly;
    logic [PAD_W-1:0]       pads;
    logic                   de_pad;
    logic                   vs_pad;
    logic                   clk_pad;
  } pro_state_s;

  pro_state_s st_q, st_d;

  pro_stream_if #(.W(FIFO_W)) fifo_in  ();
  pro_stream_if #(.W(FIFO_W)) fifo_out ();

  pro_fifo #(
    .W     (FIFO_W),
    .DEPTH (FIFO_D)
  ) u_fifo (
    .clock (clock),
    .rst_b (rst_b),
    .in_s  (fifo_in),
    .out_s (fifo_out)
  );

  assign fifo_in.valid = pix_valid;
  assign fifo_in.data  = pix_rgb;
  assign pix_ready     = fifo_in.ready;

  function automatic logic [COMP_W-1:0] rev10(input logic [COMP_W-1:0] v);
    logic [COMP_W-1:0] r;
    r = '0;
    for (int i = 0; i < COMP_W; i++) begin
      r[i] = v[COMP_W-1-i];
    end
    return r;
  endfunction : rev10

  function automatic logic [NARROW_W-1:0] rev8(input logic [NARROW_W-1:0] v);
    logic [NARROW_W-1:0] r;
    r = '0;
    for (int i = 0; i < NARROW_W; i++) begin
      r[i] = v[NARROW_W-1-i];
    end
    return r;
  endfunction : rev8

  // window test shared by both axes: start inclusive, end exclusive
  function automatic logic in_win(input logic [WIN_W-1:0] pos, input logic [31:0] win);
    logic [WIN_W-1:0] s;
    logic [WIN_W-1:0] e;
    s = win[WIN_START_LSB +: WIN_W];
    e = win[WIN_END_LSB +: WIN_W];
    return (pos >= s) && (pos < e);
  endfunction : in_win

  // format field of the block control word
  function automatic logic [FMT_W-1:0] fmt_of(input logic [31:0] ctrl);
    return ctrl[FMT_LSB +: FMT_W];
  endfunction : fmt_of

  // both multiplexed formats send a pixel in two phases
  function automatic logic is_mux(input logic [FMT_W-1:0] fmt);
    logic m;
    m = (fmt == FMT_MUX_10) || (fmt == FMT_MUX_8);
    return m;
  endfunction : is_mux

  // a pad in software function shows its level bit, else its video value
  function automatic logic pad_pick(input logic [31:0] func,
                                    input logic [31:0] level,
                                    input int          sel,
                                    input logic        video);
    logic v;
    v = func[sel] ? level[sel] : video;
    return v;
  endfunction : pad_pick

  // software overlay of the reconfigurable video pads
  function automatic logic [PAD_W-1:0] sw_overlay(input logic [PAD_W-1:0] vid,
                                                  input logic [31:0]      func,
                                                  input logic [31:0]      level);
    logic [PAD_W-1:0] p;
    p = vid;
    for (int i = 0; i < SW_PAD_CNT; i++) begin
      p[SW_PAD_FIRST + i] = pad_pick(func, level, i, vid[SW_PAD_FIRST + i]);
    end
    return p;
  endfunction : sw_overlay

  // line position holds at the top so a missing line reference never wraps into the window
  function automatic logic [WIN_W-1:0] next_hcnt(input logic [WIN_W-1:0] hcnt,
                                                 input logic             restart);
    logic [WIN_W-1:0] n;
    n = hcnt;
    if (restart) begin
      n = '0;
    end else if (hcnt != '1) begin
      n = hcnt + 1'b1;
    end
    return n;
  endfunction : next_hcnt

  // delayed data clock tap with polarity; taps trade skew against panel setup
  function automatic logic dclk_pick(input logic [31:0]          ctrl,
                                     input logic [DCLK_TAPS-1:0] taps);
    logic c;
    c = taps[ctrl[DCLK_DLY_LSB +: DCLK_DLY_W]] ^ ctrl[DCLK_POL_BIT];
    return c;
  endfunction : dclk_pick

  // register write with the read-only bits masked off; unmapped writes are dropped
  function automatic pro_state_s apply_write(input pro_state_s        s,
                                             input logic [ADDR_W-1:0] addr,
                                             input logic [31:0]       data);
    pro_state_s n;
    n = s;
    case (addr)
      OFS_BLOCK_CTRL: n.ctrl       = data & CTRL_RW_MASK;
      OFS_HSYNC_CTRL: n.hsync_ctrl = data;
      OFS_VSYNC_CTRL: n.vsync_ctrl = data;
      OFS_DE_HWIN:    n.de_hwin    = data;
      OFS_DE_VWIN:    n.de_vwin    = data;
      OFS_PAD_FUNC:   n.pad_func   = data & PAD_RW_MASK;
      OFS_PAD_LEVEL:  n.pad_level  = data & PAD_RW_MASK;
      default:        n.ctrl       = s.ctrl;
    endcase
    return n;
  endfunction : apply_write

  // read view of one word; status bits ride in the top of the block control word
  function automatic logic [31:0] read_word(input logic [ADDR_W-1:0] addr,
                                            input pro_state_s        s,
                                            input logic              fifo_busy);
    logic [31:0] w;
    w = '0;
    case (addr)
      OFS_BLOCK_CTRL: begin
        w               = s.ctrl;
        w[ST_DE_BIT]    = s.de;
        w[ST_FIFO_BIT]  = fifo_busy;
        w[ST_PHASE_BIT] = s.phase;
      end
      OFS_HSYNC_CTRL: w = s.hsync_ctrl;
      OFS_VSYNC_CTRL: w = s.vsync_ctrl;
      OFS_DE_HWIN:    w = s.de_hwin;
      OFS_DE_VWIN:    w = s.de_vwin;
      OFS_PAD_FUNC:   w = s.pad_func;
      OFS_PAD_LEVEL:  w = s.pad_level;
      default:        w = '0;
    endcase
    return w;
  endfunction : read_word

  // pad layout of one pixel for the chosen format and phase
  function automatic logic [PAD_W-1:0] map_pads(input logic [FMT_W-1:0] fmt,
                                               input logic [PIX_W-1:0] rgb,
                                               input logic ph);
    logic [COMP_W-1:0]   r, g, b;
    logic [NARROW_W-1:0] r8, g8, b8;
    logic [PAD_W-1:0]    p;
    r  = rgb[0 +: COMP_W];
    g  = rgb[COMP_W +: COMP_W];
    b  = rgb[2*COMP_W +: COMP_W];
    // narrow formats carry the most significant bits of each component
    r8 = r[COMP_W-1 -: NARROW_W];
    g8 = g[COMP_W-1 -: NARROW_W];
    b8 = b[COMP_W-1 -: NARROW_W];
    p  = '0;
    case (fmt)
      FMT_STRAIGHT_10: begin
        p = {b, g, r};
      end
      FMT_SWAP_10: begin
        p = {rev10(b), rev10(g), rev10(r)};
      end
      FMT_SWAP_8: begin
        p[3*NARROW_W-1:0] = {rev8(b8), rev8(g8), rev8(r8)};
      end
      FMT_MUX_10: begin
        if (!ph) begin
          p[14:0] = {g[8], g[3:0], b};
        end else begin
          p[14:0] = {r[8], r[7:4], r[9], g[9], r[3:0], g[7:4]};
        end
      end
      FMT_MUX_8: begin
        if (!ph) begin
          p[11:0] = {g8[3:0], b8};
        end else begin
          p[11:0] = {r8, g8[7:4]};
        end
      end
      default: begin
        p = '0;
      end
    endcase
    return p;
  endfunction : map_pads

  logic             mux_mode;
  logic             pop;
  logic             de_raw;
  logic             clk_raw;
  logic [PAD_W-1:0] vid;

  always_comb begin
    st_d     = st_q;
    mux_mode = is_mux(fmt_of(st_q.ctrl));
    // mux formats hold each pixel for two cycles, which back-pressures the fifo
    pop      = fifo_out.valid && (!mux_mode || st_q.phase);
    fifo_out.ready = pop;

    // register port
    st_d.ack   = reg_sel;
    st_d.rdata = '0;
    if (reg_sel && reg_write) begin
      st_d = apply_write(st_d, reg_addr, reg_wdata);
    end else if (reg_sel) begin
      st_d.rdata = read_word(reg_addr, st_q, fifo_out.valid);
    end

    // horizontal position restarts on the rising edge of the line reference
    st_d.hs_prev = pixel_hsync_ref;
    st_d.hcnt    = next_hcnt(st_q.hcnt, pixel_hsync_ref && !st_q.hs_prev);
    // vertical reset wins over any programmed window
    de_raw  = !pixel_vertical_reset_ref
           && in_win(st_q.hcnt, st_q.de_hwin)
           && in_win(pixel_line_counter, st_q.de_vwin);
    st_d.de = de_raw;

    // pixel phase advances only while a pixel is held, so phase 0 always leads
    if (!mux_mode) begin
      st_d.phase = 1'b0;
    end else if (fifo_out.valid) begin
      st_d.phase = !st_q.phase;
    end

    // data clock: toggle per cycle, or per two cycles when divided
    st_d.clk_tgl = !st_q.clk_tgl;
    if (st_q.clk_tgl) begin
      st_d.clk_div = !st_q.clk_div;
    end
    clk_raw      = st_q.ctrl[DCLK_DIV_BIT] ? st_q.clk_div : st_q.clk_tgl;
    st_d.clk_dly = {st_q.clk_dly[DCLK_TAPS-2:0], clk_raw};

    // pads: an empty fifo drives zero rather than stale data
    vid = fifo_out.valid ? map_pads(fmt_of(st_q.ctrl), fifo_out.data, st_q.phase) : '0;
    // pads are registered so a level shows one edge after its register write lands
    st_d.pads    = sw_overlay(vid, st_q.pad_func, st_q.pad_level);
    st_d.de_pad  = pad_pick(st_q.pad_func, st_q.pad_level, PADSEL_DE,
                            st_q.de ^ st_q.ctrl[DE_POL_BIT]);
    st_d.vs_pad  = pad_pick(st_q.pad_func, st_q.pad_level, PADSEL_VSYNC,
                            pixel_vsync_ref);
    st_d.clk_pad = pad_pick(st_q.pad_func, st_q.pad_level, PADSEL_DCLK,
                            dclk_pick(st_q.ctrl, st_q.clk_dly));
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // pads never tri-state: push-pull in video and software function alike
  assign video_pad       = st_q.pads;
  assign data_enable_pad = st_q.de_pad;
  assign vsync_pad       = st_q.vs_pad;
  assign data_clock_pad  = st_q.clk_pad;
  assign reg_rdata       = st_q.rdata;
  assign reg_ack         = st_q.ack;
endmodule : pro_output_stage

// *** shared/pro_pkg.sv ***
// Purpose: constants shared by the panel rgb output stage
// Assumes: one pixel clock domain, 32-bit register words
// Notes:   register offsets are byte offsets on the dedicated register port
package pro_pkg;
  // register byte offsets
  localparam logic [4:0] OFS_BLOCK_CTRL = 5'h00;
  localparam logic [4:0] OFS_HSYNC_CTRL = 5'h04;
  localparam logic [4:0] OFS_VSYNC_CTRL = 5'h08;
  localparam logic [4:0] OFS_DE_HWIN    = 5'h0C;
  localparam logic [4:0] OFS_DE_VWIN    = 5'h10;
  localparam logic [4:0] OFS_PAD_FUNC   = 5'h14;
  localparam logic [4:0] OFS_PAD_LEVEL  = 5'h18;
  localparam int         ADDR_W         = 5;
  // output_block_control fields
  localparam int FMT_LSB      = 0;
  localparam int FMT_W        = 3;
  localparam int DE_POL_BIT   = 3;
  localparam int DCLK_POL_BIT = 4;
  localparam int DCLK_DLY_LSB = 5;
  localparam int DCLK_DLY_W   = 2;
  localparam int DCLK_DIV_BIT = 7;
  localparam int ST_PHASE_BIT = 29;
  localparam int ST_FIFO_BIT  = 30;
  localparam int ST_DE_BIT    = 31;
  localparam logic [31:0] CTRL_RW_MASK = 32'h0000_00FF;
  // window registers: start in low half, end in high half
  localparam int WIN_W        = 12;
  localparam int WIN_START_LSB = 0;
  localparam int WIN_END_LSB  = 16;
  // pad control bit layout
  localparam int SW_PAD_FIRST = 12;
  localparam int SW_PAD_CNT   = 18;
  localparam int PADSEL_DE    = 18;
  localparam int PADSEL_VSYNC = 19;
  localparam int PADSEL_DCLK  = 20;
  localparam logic [31:0] PAD_RW_MASK = 32'h001F_FFFF;
  // geometry
  localparam int COMP_W   = 10;
  localparam int NARROW_W = 8;
  localparam int PAD_W    = 30;
  localparam int PIX_W    = 3 * COMP_W;
  localparam int DCLK_TAPS = 4;
  localparam int FIFO_DEPTH = 8;
  // output formats
  typedef enum logic [FMT_W-1:0] {
    FMT_STRAIGHT_10 = 3'h0,
    FMT_SWAP_10     = 3'h1,
    FMT_SWAP_8      = 3'h2,
    FMT_MUX_10      = 3'h3,
    FMT_MUX_8       = 3'h4
  } pro_fmt_e;
endpackage : pro_pkg

// *** shared/pro_stream_if.sv ***
// Purpose: valid/ready pixel stream between stage modules
// Assumes: single clock
// Notes:   data is held stable while valid and not ready
`timescale 1ns/100ps
interface pro_stream_if #(parameter int W = 30);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : pro_stream_if

// *** tb/panel_rgb_output_stage_tb_top.sv ***
// Purpose: self-checking bench for the panel rgb output stage
// Assumes: pixel clock 125 MHz, reset held 20 cycles
// Notes:   pad words compared against a bench mapping of each format
`timescale 1ns/100ps
module panel_rgb_output_stage_tb_top;
  import pro_pkg::*;
  logic clock, rst_b, reg_sel, reg_write, pix_valid, pix_ready, reg_ack, rec;
  logic [ADDR_W-1:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, lf;
  logic [PIX_W-1:0] pix_rgb;
  logic pixel_hsync_ref, pixel_vertical_reset_ref, pixel_vsync_ref;
  logic [WIN_W-1:0] pixel_line_counter;
  logic [PAD_W-1:0] video_pad;
  logic data_enable_pad, vsync_pad, data_clock_pad, s0, s1;
  int errors, samples_checked, refused;
  logic [PIX_W-1:0] q[$];
  logic [4:0] ra[5] = '{5'h00, 5'h04, 5'h08, 5'h14, 5'h18};
  logic [31:0] rm[5] = '{32'hFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h1F_FFFF, 32'h1F_FFFF};
  pro_output_stage DUT (.clock, .rst_b, .reg_sel, .reg_write, .reg_addr, .reg_wdata,
    .reg_rdata, .reg_ack, .pix_valid, .pix_rgb, .pix_ready, .pixel_hsync_ref,
    .pixel_vertical_reset_ref, .pixel_line_counter, .pixel_vsync_ref, .video_pad,
    .data_enable_pad, .vsync_pad, .data_clock_pad);
  pro_panel_model panel (.clock, .rec, .video_pad, .data_enable_pad);
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  always @(posedge clock) begin
    lf <= lfsr(lf);
    pix_rgb <= lf[29:0];
    pixel_vsync_ref <= lf[31];
    if (pix_valid && pix_ready) q.push_back(pix_rgb);
    else if (pix_valid) refused++;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_sel <= 1'b1;
    reg_write <= w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_sel <= 1'b0;
    #1;
  endtask : acc
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
    chk(reg_ack, 1);
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk(reg_rdata, e);
  endtask : rd
  function automatic logic [29:0] pmap(input int f, input logic [29:0] x, input bit ph);
    logic [9:0] r, g, b;
    logic [29:0] p;
    r = x[9:0];
    g = x[19:10];
    b = x[29:20];
    p = '0;
    case (f)
      0: p = x;
      1: for (int i = 0; i < 10; i++) begin
        p[i] = r[9-i];
        p[10+i] = g[9-i];
        p[20+i] = b[9-i];
      end
      2: for (int i = 0; i < 8; i++) begin
        p[i] = r[9-i];
        p[8+i] = g[9-i];
        p[16+i] = b[9-i];
      end
      3: p[14:0] = ph ? {r[8], r[7:4], r[9], g[9], r[3:0], g[7:4]} : {g[8], g[3:0], b};
      4: p[11:0] = ph ? {r[9:2], g[9:6]} : {g[5:2], b[9:2]};
      default: p = '0;
    endcase
    return p;
  endfunction : pmap
  task automatic stream(input int f);
    int st;
    wr(OFS_BLOCK_CTRL, 32'(f));
    @(posedge clock);
    q.delete();
    panel.log_q.delete();
    refused = 0;
    rec <= 1'b1;
    pix_valid <= 1'b1;
    repeat (20) @(posedge clock);
    pix_valid <= 1'b0;
    repeat (48) @(posedge clock);
    rec <= 1'b0;
    @(posedge clock);
    st = (f > 2) ? 2 : 1;
    foreach (q[k]) begin
      chk(panel.log_q[2+st*k], pmap(f, q[k], 0));
      if (st == 2) chk(panel.log_q[3+st*k], pmap(f, q[k], 1));
    end
    chk(panel.log_q[$], 32'h0);
    chk(32'(refused > 0), 32'(f > 2));
    chk(pix_ready, 1);
  endtask : stream
  task automatic de_run(input logic [11:0] ln, input logic vr, input logic pol, input int e);
    wr(OFS_BLOCK_CTRL, {28'h0, pol, 3'h0});
    @(posedge clock);
    panel.de_hi = 0;
    panel.n_rec = 0;
    rec <= 1'b1;
    pixel_line_counter <= ln;
    pixel_vertical_reset_ref <= vr;
    pixel_hsync_ref <= 1'b1;
    @(posedge clock);
    pixel_hsync_ref <= 1'b0;
    repeat (15) @(posedge clock);
    rec <= 1'b0;
    @(posedge clock);
    chk(pol ? panel.n_rec - panel.de_hi : panel.de_hi, e);
  endtask : de_run
  task automatic conclude;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude
  initial begin
    repeat (6000) @(posedge clock);
    errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    conclude;
  end
  initial begin
    rst_b = 1'b0;
    reg_sel = 1'b0;
    reg_write = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    pix_valid = 1'b0;
    pix_rgb = '0;
    lf = 32'h5416;
    rec = 1'b0;
    pixel_hsync_ref = 1'b0;
    pixel_vertical_reset_ref = 1'b1;
    pixel_vsync_ref = 1'b0;
    pixel_line_counter = '0;
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    for (int i = 0; i < 8; i++) rd(5'(i * 4), 32'h0);
    foreach (ra[i]) wr(ra[i], 32'hFFFF_FFFF);
    wr(5'h1C, 32'hFFFF_FFFF);
    foreach (ra[i]) rd(ra[i], rm[i]);
    rd(5'h1C, 32'h0);
    chk(video_pad, 30'h3FFF_F000);
    chk({data_clock_pad, vsync_pad, data_enable_pad}, 3'h7);
    wr(OFS_PAD_LEVEL, 32'h0);
    chk(video_pad, 30'h3FFF_F000);
    @(posedge clock);
    #1 chk(video_pad, 30'h0);
    wr(OFS_PAD_FUNC, 32'h0);
    $display("registers and pads done");
    for (int d = 0; d < 8; d++) begin
      wr(OFS_BLOCK_CTRL, {24'h0, d[2], d[1:0], d[0], 4'h0});
      repeat (8) @(posedge clock);
      #1 s0 = data_clock_pad;
      @(posedge clock);
      #1 s1 = data_clock_pad;
      if (!d[2]) chk(32'(s1 != s0), 1);
      @(posedge clock);
      #1 chk(32'(data_clock_pad != s0), 32'(d[2]));
    end
    $display("data clock done");
    for (int f = 0; f < 5; f++) stream(f);
    $display("formats done");
    wr(OFS_DE_HWIN, 32'h0005_0002);
    wr(OFS_DE_VWIN, 32'h0003_0001);
    de_run(12'h2, 1'b0, 1'b0, 3);
    de_run(12'h1, 1'b0, 1'b1, 3);
    de_run(12'h3, 1'b0, 1'b0, 0);
    de_run(12'h2, 1'b1, 1'b0, 0);
    $display("data enable done");
    conclude;
  end
endmodule : panel_rgb_output_stage_tb_top

// *** tb/pro_output_stage_sva.sv ***
// Purpose: port checks for the panel rgb output stage
// Assumes: one pixel clock, async active-low reset
// Notes:   register shadows rebuilt from writes, so no view of the body
`timescale 1ns/100ps
module pro_output_stage_sva
  import pro_pkg::*;
(
  // clock and reset
  input wire logic                       clock,
  input wire logic                       rst_b,
  // register port
  input wire logic                       reg_sel,
  input wire logic                       reg_write,
  input wire logic [pro_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0]                reg_wdata,
  input wire logic [31:0]                reg_rdata,
  input wire logic                       reg_ack,
  // references and pads
  input wire logic                       pixel_vertical_reset_ref,
  input wire logic                       pixel_vsync_ref,
  input wire logic [pro_pkg::PAD_W-1:0]  video_pad,
  input wire logic                       data_enable_pad,
  input wire logic                       vsync_pad,
  input wire logic                       data_clock_pad
);
  logic [7:0]  ctrl_q;
  logic [20:0] func_q;
  logic [20:0] lvl_q;
  logic        up_q;
  wire         wr0 = reg_sel && reg_write && reg_addr == OFS_BLOCK_CTRL;
  // up_q masks the first edge after reset, where pads are still held low
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= 8'h00;
      func_q <= 21'h0;
      lvl_q  <= 21'h0;
      up_q   <= 1'b0;
    end else begin
      up_q <= 1'b1;
      if (wr0) ctrl_q <= reg_wdata[7:0];
      if (reg_sel && reg_write && reg_addr == OFS_PAD_FUNC) func_q <= reg_wdata[20:0];
      if (reg_sel && reg_write && reg_addr == OFS_PAD_LEVEL) lvl_q <= reg_wdata[20:0];
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  a_ack_follows_sel: assert property (reg_ack == $past(reg_sel))
    else $error("ack not one cycle after select");
  a_rdata_idle_zero: assert property (!(reg_sel && !reg_write) |=> reg_rdata == 32'h0)
    else $error("read data outside a read answer");
  a_de_reset_off: assert property (up_q && pixel_vertical_reset_ref && !wr0 && !func_q[18]
    ##1 !wr0 && !func_q[18] |=> data_enable_pad == ctrl_q[3])
    else $error("data enable not off under vertical reset");
  a_vsync_video_path: assert property (up_q && !func_q[19]
    |=> vsync_pad == $past(pixel_vsync_ref)) else $error("vsync pad not following reference");
  a_vsync_sw_level: assert property (up_q && func_q[19] |=> vsync_pad == $past(lvl_q[19]))
    else $error("vsync software level wrong");
  a_swap8_high_zero: assert property ((ctrl_q[2:0] == 3'h2 && func_q[17:12] == 6'h0)[*2]
    |=> video_pad[29:24] == 6'h0) else $error("narrow swap upper pads not zero");
  a_mux10_high_zero: assert property ((ctrl_q[2:0] == 3'h3 && func_q[17:3] == 15'h0)[*2]
    |=> video_pad[29:15] == 15'h0) else $error("mux upper pads not zero");
  a_dclk_full_rate: assert property ((up_q && !ctrl_q[7] && !func_q[20] && $stable(ctrl_q))[*5]
    |=> data_clock_pad != $past(data_clock_pad)) else $error("data clock not toggling");
  a_dclk_half_rate: assert property ((up_q && ctrl_q[7] && !func_q[20] && $stable(ctrl_q))[*6]
    |=> data_clock_pad != $past(data_clock_pad, 2)) else $error("divided data clock wrong");
endmodule : pro_output_stage_sva
bind pro_output_stage pro_output_stage_sva chk (.clock, .rst_b, .reg_sel, .reg_write,
  .reg_addr, .reg_wdata, .reg_rdata, .reg_ack, .pixel_vertical_reset_ref, .pixel_vsync_ref,
  .video_pad, .data_enable_pad, .vsync_pad, .data_clock_pad);

// *** tb/pro_panel_model.sv ***
// Purpose: panel side model logging what reaches the pads
// Assumes: the panel samples on the rising pixel clock edge
// Notes:   log and counters are cleared by the bench while rec is low
`timescale 1ns/100ps
module pro_panel_model
  import pro_pkg::*;
(
  // clock
  input wire logic                      clock,
  // capture window
  input wire logic                      rec,
  // pads
  input wire logic [pro_pkg::PAD_W-1:0] video_pad,
  input wire logic                      data_enable_pad
);
  logic [PAD_W-1:0] log_q[$];
  int               de_hi;
  int               n_rec;
  // a panel only listens, it never drives back
  always @(posedge clock) begin
    if (rec) begin
      log_q.push_back(video_pad);
      n_rec += 1;
      de_hi += int'(data_enable_pad);
    end
  end
endmodule : pro_panel_model
